// ---- design/rsx_exec.v ----
// execution unit for return from interrupt, return with literal and test-skip-if-zero
// Overview of operation
// [RULE1] return_from_interrupt_op pops stack_top into the pc and sets the high or low global enable over two cycles.
// [RULE2] with the fast bit set, working, flags and bank select registers are restored from their shadows.
// [RULE3] return_with_literal_op loads the working register with k and the pc from stack_top over two cycles.
// [RULE4] both returns leave pc_upper_latch and pc_high_latch untouched.
// [RULE5] test_skip_if_zero_op on a zero operand discards the fetched next instruction and runs a nop in its place.
// [RULE6] the access bit selects the access bank when clear and the bank_select_reg bank when set.
// [RULE7] access bit clear with extended set enabled and address up to 95 uses indexed literal offset addressing.
// [RULE8] each cycle has decode, read, process and write-back phases, and flushed cycles do nothing in all of them.
`timescale 1ns/1ps
`include "rsx_defs.vh"
module rsx_exec (
    input  wire        clk_i,
    input  wire        nrst_i,
    input  wire        ce_i,
    // instruction stream and mode levels
    input  wire [15:0] instr_i,          // instruction presented at decode
    input  wire        instr_valid_i,
    input  wire [20:0] stack_top_i,
    input  wire        priority_mode_i,   // 1: high/low priority scheme
    input  wire        in_high_isr_i,     // returning from high priority service
    input  wire        ext_set_en_i,
    input  wire [7:0]  file_rdata_i,      // operand read back, sampled in process phase
    // values read back from the register file side
    input  wire [7:0]  working_shadow_i,
    input  wire [7:0]  flags_shadow_i,
    input  wire [3:0]  bank_shadow_i,
    input  wire [3:0]  bank_select_reg_i,
    input  wire [7:0]  fsr2_base_i,       // base for indexed literal offset
    // registered results; strobes last one clock while ce_i is high
    output reg  [3:0]  phase_o,
    output reg  [11:0] file_addr_o,
    output reg         file_rd_o,
    output reg         pc_load_o,
    output reg  [20:0] pc_o,
    output reg         stack_pop_o,
    output reg         w_load_o,
    output reg  [7:0]  w_o,
    output reg         flags_load_o,
    output reg  [7:0]  flags_o,
    output reg         bank_load_o,
    output reg  [3:0]  bank_o,
    output reg         high_priority_global_enable_set_o,
    output reg         low_priority_global_enable_set_o,
    output reg         pclat_we_o,        // never raised by these instructions
    output reg         skip_o,
    output reg         busy_o
);
    // internal phase ring; phase_o is its registered copy
    wire [3:0]  ph;
    reg  [15:0] op_reg;
    reg         flush_reg;   // current cycle is a discarded one
    reg         second_reg;  // second cycle of a two-cycle return
    reg  [1:0]  kind_reg;
    // instruction classes held for the rest of the cycle
    localparam K_NONE = 2'h0;
    localparam K_RFI  = 2'h1;
    localparam K_RLW  = 2'h2;
    localparam K_TSZ  = 2'h3;

    // four-clock phase ring shared by all instructions
    rsx_phase_gen u_phase (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .ce_i    (ce_i),
        .phase_o (ph)
    );

    // decode function applied to the incoming word at decode
    function [1:0] classify;
        input [15:0] w;
        begin
            if ((w & `RSX_RETFI_MASK) == `RSX_RETFI_CODE) classify = K_RFI;
            else if ((w & `RSX_RETLIT_MASK) == `RSX_RETLIT_CODE) classify = K_RLW;
            else if ((w & `RSX_TSZ_MASK) == `RSX_TSZ_CODE) classify = K_TSZ;
            else classify = K_NONE;
        end
    endfunction

    // operand address formation
    function [11:0] fadr;
        input [15:0] w;
        input        ext;
        input [3:0]  bank_select_reg;
        input [7:0]  base;
        reg   [7:0]  sum;
        begin
            // offset wraps inside the 8-bit window; the carry is dropped on purpose
            sum = base + w[7:0];
            // access bit set: bank from bank_select_reg; clear: access bank or indexed offset
            if (w[`RSX_ACC_BIT])
                fadr = {bank_select_reg, w[7:0]}; // see [RULE6]
            else if (ext && w[7:0] <= `RSX_ILO_MAX)
                fadr = {4'h0, sum}; // see [RULE7]
            else if (w[7:0] < `RSX_ACC_SPLIT)
                fadr = {4'h0, w[7:0]}; // see [RULE6]
            else
                fadr = {`RSX_ACC_HI_BANK, w[7:0]};
        end
    endfunction

    // sequencing; nothing happens in a flushed or second cycle; the pop comes in the first cycle's write-back
    // the word fetched behind a taken skip or a return is dropped here at decode, so the
    // fetch side never has to cancel it; the register file must answer file_rd_o within
    // one clock, because the operand is sampled in the process phase
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            // internal state
            op_reg <= 16'h0000;
            kind_reg <= K_NONE;
            flush_reg <= 1'b0;
            second_reg <= 1'b0;
            // outputs
            phase_o <= `RSX_PH_DEC;
            file_addr_o <= 12'h000;
            file_rd_o <= 1'b0;
            pc_load_o <= 1'b0;
            pc_o <= 21'h00000;
            stack_pop_o <= 1'b0;
            w_load_o <= 1'b0;
            w_o <= 8'h00;
            flags_load_o <= 1'b0;
            flags_o <= 8'h00;
            bank_load_o <= 1'b0;
            bank_o <= 4'h0;
            high_priority_global_enable_set_o <= 1'b0;
            low_priority_global_enable_set_o <= 1'b0;
            pclat_we_o <= 1'b0;
            skip_o <= 1'b0;
            busy_o <= 1'b0;
        end else if (ce_i) begin
            phase_o <= ph;
            // every strobe is a single-clock pulse unless a phase below raises it again
            file_rd_o <= 1'b0;
            pc_load_o <= 1'b0;
            stack_pop_o <= 1'b0;
            w_load_o <= 1'b0;
            flags_load_o <= 1'b0;
            bank_load_o <= 1'b0;
            skip_o <= 1'b0;
            high_priority_global_enable_set_o <= 1'b0;
            low_priority_global_enable_set_o <= 1'b0;
            pclat_we_o <= 1'b0; // see [RULE4]

            case (ph)
                // decode: a new word is taken only in a live cycle
                `RSX_PH_DEC: begin
                    if (flush_reg || second_reg) begin
                        // discarded instruction word behaves as a nop
                        kind_reg <= K_NONE; // see [RULE8]
                        flush_reg <= 1'b0;
                        second_reg <= 1'b0;
                        busy_o <= 1'b0;
                    end else if (instr_valid_i) begin
                        // unknown opcodes classify as K_NONE and run as a nop
                        op_reg <= instr_i;
                        kind_reg <= classify(instr_i);
                        busy_o <= (classify(instr_i) != K_NONE);
                    end else begin
                        kind_reg <= K_NONE;
                    end
                end

                // read: fetch the operand, or stage the literal; w_load_o strobes only at write-back
                `RSX_PH_RD: begin
                    if (kind_reg == K_TSZ) begin
                        file_addr_o <= fadr(op_reg, ext_set_en_i, bank_select_reg_i, fsr2_base_i);
                        file_rd_o <= 1'b1;
                    end else if (kind_reg == K_RLW) begin
                        w_o <= op_reg[7:0];
                    end
                end

                // process: decide the skip from the operand read back
                `RSX_PH_PROC: begin
                    // zero operand flushes the prefetched word
                    if (kind_reg == K_TSZ && file_rdata_i == 8'h00) begin
                        flush_reg <= 1'b1; // see [RULE5]
                        skip_o <= 1'b1;
                    end
                end

                // write-back: pop and restores; high and low enables are never set together
                `RSX_PH_WB: begin
                    if (kind_reg == K_RFI || kind_reg == K_RLW) begin
                        // pc from stack only; latches are left alone
                        pc_o <= stack_top_i; // see [RULE4]
                        pc_load_o <= 1'b1; // see [RULE1] [RULE3]
                        stack_pop_o <= 1'b1;
                        second_reg <= 1'b1; // two cycle return
                    end
                    // the literal already sits in w_o since the read phase
                    if (kind_reg == K_RLW) begin
                        w_load_o <= 1'b1; // see [RULE3]
                    end
                    if (kind_reg == K_RFI) begin
                        // non-priority mode: high enable acts as the global enable
                        if (!priority_mode_i || in_high_isr_i)
                            high_priority_global_enable_set_o <= 1'b1; // see [RULE1]
                        else
                            low_priority_global_enable_set_o <= 1'b1; // see [RULE1]
                        if (op_reg[`RSX_FAST_BIT]) begin
                            w_o <= working_shadow_i; // see [RULE2]
                            w_load_o <= 1'b1;
                            flags_o <= flags_shadow_i;
                            flags_load_o <= 1'b1;
                            bank_o <= bank_shadow_i;
                            bank_load_o <= 1'b1;
                        end
                    end
                    // a taken skip stays busy until the decode phase of its flushed cycle
                    if (kind_reg == K_TSZ && !flush_reg) busy_o <= 1'b0;
                end

                // not reachable while the ring stays one-hot
                default: begin
                    kind_reg <= K_NONE;
                end
            endcase
        end
    end
endmodule // rsx_exec

// ---- design/rsx_defs.vh ----
// constants for the return and skip instruction execution unit
`ifndef RSX_DEFS_VH
`define RSX_DEFS_VH
`define RSX_OPC_W        16
`define RSX_RETFI_MASK   16'hFFFE
`define RSX_RETFI_CODE   16'h0010
`define RSX_RETLIT_MASK  16'hFF00
`define RSX_RETLIT_CODE  16'h0C00
`define RSX_TSZ_MASK     16'hFE00
`define RSX_TSZ_CODE     16'h6600
`define RSX_FAST_BIT     0
`define RSX_ACC_BIT      8
`define RSX_ILO_MAX      8'h5F
`define RSX_ACC_SPLIT    8'h60
`define RSX_ACC_HI_BANK  4'hF
`define RSX_PH_DEC       4'h1
`define RSX_PH_RD        4'h2
`define RSX_PH_PROC      4'h4
`define RSX_PH_WB        4'h8
`endif

// ---- design/rsx_phase_gen.v ----
// four phase sequencer of one instruction cycle
`timescale 1ns/1ps
`include "rsx_defs.vh"
module rsx_phase_gen (
    input  wire       clk_i,
    input  wire       nrst_i,
    input  wire       ce_i,
    output reg  [3:0] phase_o
);
    // one-hot ring; each instruction cycle is four clocks
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase_o <= `RSX_PH_DEC;
        end else if (ce_i) begin
            phase_o <= {phase_o[2:0], phase_o[3]}; // see [RULE8]
        end
    end
endmodule // rsx_phase_gen

// ---- tb/rsx_exec_chk.sv ----
// assertion checker for the return and skip execution unit
`timescale 1ns/1ps
module rsx_exec_chk (
    input wire        clk_i,
    input wire        nrst_i,
    input wire [20:0] stack_top_i,
    input wire [3:0]  phase_o,
    input wire        file_rd_o,
    input wire        pc_load_o,
    input wire [20:0] pc_o,
    input wire        stack_pop_o,
    input wire        w_load_o,
    input wire        flags_load_o,
    input wire        bank_load_o,
    input wire        high_priority_global_enable_set_o,
    input wire        low_priority_global_enable_set_o,
    input wire        pclat_we_o,
    input wire        skip_o
);
    wire eh = high_priority_global_enable_set_o;
    wire el = low_priority_global_enable_set_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_pclat_held: assert property (!pclat_we_o) else $error("pc latch written");
    a_pop_loads_pc: assert property (stack_pop_o |-> pc_load_o && pc_o == $past(stack_top_i))
        else $error("pc not from stack");
    a_enable_pair: assert property ((eh || el) |-> stack_pop_o && !(eh && el)) else $error("bad enable set");
    a_shadow_group: assert property (bank_load_o |-> flags_load_o && w_load_o && stack_pop_o)
        else $error("partial restore");
    a_return_gap: assert property (pc_load_o |=> !pc_load_o [*7]) else $error("next cycle not flushed");
    a_skip_flush: assert property (skip_o |=> !(pc_load_o || file_rd_o) [*6])
        else $error("skipped cycle active");
    a_read_first: assert property (skip_o |-> $past(file_rd_o)) else $error("skip without read");
    a_phase_ring: assert property ($onehot(phase_o)) else $error("phase not one-hot");
    c_skip: cover property (skip_o);
    c_high: cover property (eh);
    c_low: cover property (el);
endmodule // rsx_exec_chk
bind rsx_exec rsx_exec_chk i_rsx_exec_chk (.*);

// ---- tb/rsx_exec_bench.sv ----
// self-checking bench for the return and skip execution unit
`timescale 1ns/1ps
module rsx_exec_bench;
    reg         clk_i = 0, nrst_i = 0, vld = 0, pm = 0, hi = 0, ext = 0, ce = 1;
    reg  [15:0] ins = 16'h0000;
    reg  [20:0] stack_top = 21'h0;
    reg  [7:0]  rd = 8'h00, ws = 8'h00, fs = 8'h00, base = 8'h00;
    reg  [3:0]  bs = 4'h0, bank_select_reg = 4'h0;
    wire [3:0]  ph, bk;
    wire [11:0] fa;
    wire [20:0] pc;
    wire [7:0]  w, f;
    wire        frd, pcl, pop, wl, fl, bl, eh, el, pw, sk, by;
    reg  [63:0] q[$];
    reg  [31:0] r;
    integer     seed = 32'h523664F9, n_mismatch = 0, total_checks = 0, cyc = 0, i, stall = 0;
    rsx_exec i_rsx_exec (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce), .instr_i(ins), .instr_valid_i(vld),
        .stack_top_i(stack_top), .priority_mode_i(pm), .in_high_isr_i(hi), .ext_set_en_i(ext), .file_rdata_i(rd),
        .working_shadow_i(ws), .flags_shadow_i(fs), .bank_shadow_i(bs), .bank_select_reg_i(bank_select_reg),
        .fsr2_base_i(base), .phase_o(ph), .file_addr_o(fa), .file_rd_o(frd), .pc_load_o(pcl), .pc_o(pc),
        .stack_pop_o(pop), .w_load_o(wl), .w_o(w), .flags_load_o(fl), .flags_o(f), .bank_load_o(bl),
        .bank_o(bk), .high_priority_global_enable_set_o(eh), .low_priority_global_enable_set_o(el),
        .pclat_we_o(pw), .skip_o(sk), .busy_o(by));
    always #4 clk_i = ~clk_i;
    task chk(input [63:0] s, input [8*9:1] nm);
        reg [63:0] e;
        begin
            e = q.size() ? q.pop_front() : 64'h0;
            total_checks = total_checks + 1;
            if (e !== s) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected %0s: expected %h seen %h", nm, e, s);
            end
        end
    endtask
    task finish_test;
        begin
            if (q.size() != 0) chk(64'h0, "leftover");
            $display("checks %0d mismatches %0d", total_checks, n_mismatch);
            if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    // watcher: each result pulse takes the oldest note off the queue; a frozen pulse counts once
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (ce && frd) chk({2'd1, 45'd0, ph, by, fa}, "file read");
        if (ce && sk) chk({2'd2, 57'd0, ph, by}, "skip");
        if (ce && pcl) chk({2'd3, 14'd0, by, pw, pc, wl, w & {8{wl}}, fl, f & {8{fl}},
            bl, bk & {4{bl}}, eh, el}, "return");
        if (cyc == 2000) begin
            n_mismatch = n_mismatch + 1;
            finish_test;
        end
    end
    // one instruction held for n edges, then idle; the note is written before results can show
    task op(input [15:0] c, input [7:0] d, input integer n);
        reg [7:0] k;
        begin
            k = c[7:0];
            stack_top <= $random(seed);
            {ws, fs, bs, bank_select_reg, base} <= $random(seed);
            rd <= d;
            ins <= c;
            vld <= 1'b1;
            ce <= (stall == 0);
            #1;
            if (c[15:9] == 7'h33) begin
                q.push_back({2'd1, 45'd0, 4'h2, 1'b1, c[8] ? {bank_select_reg, k} : (ext && k < 8'h60) ? {4'h0, base + k}
                    : {(k < 8'h60) ? 4'h0 : 4'hF, k}});
                if (d == 8'h00) q.push_back({2'd2, 57'd0, 4'h4, 1'b1});
            end
            else if (c[15:8] == 8'h0C) q.push_back({2'd3, 14'd0, 1'b1, 1'b0, stack_top, 1'b1, k, 9'h000, 5'h00, 2'b00});
            else if (c[15:1] == 15'h0008) q.push_back({2'd3, 14'd0, 1'b1, 1'b0, stack_top, c[0], ws & {8{c[0]}}, c[0],
                fs & {8{c[0]}}, c[0], bs & {4{c[0]}}, hi | !pm, pm & !hi});
            // a stall freezes the ring, so the word is taken stall clocks later and only once
            if (stall > 0) begin
                repeat (stall) @(posedge clk_i);
                ce <= 1'b1;
            end
            repeat (n) @(posedge clk_i);
            vld <= 1'b0;
            ins <= $random(seed);
            repeat (4) @(posedge clk_i);
            $display("op %h done", c);
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        op(16'h0C5A, 8'h11, 4);
        op(16'h0010, 8'h00, 8);
        pm <= 1'b1;
        op(16'h0011, 8'h00, 4);
        hi <= 1'b1;
        op(16'h0011, 8'h00, 4);
        op(16'h6642, 8'h00, 8);
        op(16'h6670, 8'h05, 4);
        op(16'h6733, 8'h00, 4);
        stall = 4;
        op(16'h6781, 8'h3C, 4);
        stall = 0;
        ext <= 1'b1;
        op(16'h665F, 8'h00, 4);
        op(16'h6660, 8'h01, 4);
        for (i = 0; i < 24; i = i + 1) begin
            r = $random(seed);
            ext <= r[24];
            op({7'h33, r[8:0]}, r[9] ? 8'h00 : r[23:16], 4);
        end
        finish_test;
    end
endmodule // rsx_exec_bench
